// [rtl/ssdf_pkg.sv]
// Package for the sense data formatter: byte positions, codes and carrier structs.
// Assumes a single core clock domain; shared by the formatter and its bench.
package ssdf_pkg;

    localparam logic [6:0] SSDF_RC_CUR_FIXED  = 7'h70;
    localparam logic [6:0] SSDF_RC_DEF_FIXED  = 7'h71;
    localparam logic [6:0] SSDF_RC_CUR_DESC   = 7'h72;
    localparam logic [6:0] SSDF_RC_DEF_DESC   = 7'h73;

    localparam logic [7:0] SSDF_OP_LONG_READ  = 8'h3E;
    localparam logic [7:0] SSDF_OP_LONG_WRITE = 8'h3F;

    localparam logic [7:0] SSDF_ADD_LEN       = 8'h18;
    localparam logic [7:0] SSDF_FIXED_LEN     = 8'h20;
    localparam logic [7:0] SSDF_DESC_LEN      = 8'h3C;
    localparam logic [7:0] SSDF_ZERO_BYTE     = 8'h00;
    localparam logic [31:0] SSDF_INFO_ZERO    = 32'h0000_0000;

    localparam int SSDF_VALID_BIT = 7;
    localparam int SSDF_LMF_BIT   = 5;

    localparam logic [3:0] SSDF_KEY_NONE      = 4'h0;
    localparam logic [3:0] SSDF_KEY_RECOVERED = 4'h1;
    localparam logic [3:0] SSDF_KEY_NOT_READY = 4'h2;
    localparam logic [3:0] SSDF_KEY_MEDIUM    = 4'h3;
    localparam logic [3:0] SSDF_KEY_HARDWARE  = 4'h4;
    localparam logic [3:0] SSDF_KEY_ILLEGAL   = 4'h5;
    localparam logic [3:0] SSDF_KEY_UNIT_ATTN = 4'h6;
    localparam logic [3:0] SSDF_KEY_PROTECT   = 4'h7;
    localparam logic [3:0] SSDF_KEY_VENDOR    = 4'h9;
    localparam logic [3:0] SSDF_KEY_ABORTED   = 4'hB;
    localparam logic [3:0] SSDF_KEY_MISCMP    = 4'hE;

    // Byte indices inside the 32-byte fixed block.
    localparam logic [4:0] SSDF_B_CODE  = 5'h00;
    localparam logic [4:0] SSDF_B_FLAGS = 5'h02;
    localparam logic [4:0] SSDF_B_INFO0 = 5'h03;
    localparam logic [4:0] SSDF_B_INFO3 = 5'h06;
    localparam logic [4:0] SSDF_B_ALEN  = 5'h07;
    localparam logic [4:0] SSDF_B_ASC   = 5'h0C;
    localparam logic [4:0] SSDF_B_ASCQ  = 5'h0D;
    localparam logic [4:0] SSDF_B_KSF   = 5'h0F;
    localparam logic [4:0] SSDF_B_KSB0  = 5'h10;
    localparam logic [4:0] SSDF_B_KSB1  = 5'h11;
    localparam logic [4:0] SSDF_B_VEN0  = 5'h14;
    localparam logic [4:0] SSDF_B_VEN3  = 5'h17;
    localparam logic [4:0] SSDF_B_CSI0  = 5'h18;
    localparam logic [4:0] SSDF_B_CSI5  = 5'h1D;

    // Error report handed in by the command engine.
    typedef struct packed {
        logic        deferred;
        logic        descFormat;
        logic        requestSense;
        logic [7:0]  allocLen;
        logic [7:0]  opcode;
        logic [3:0]  senseKey;
        logic        infoValid;
        logic        lengthMismatch;
        logic [63:0] infoValue;
        logic [7:0]  addCode;
        logic [7:0]  addQual;
        logic        keySpecificValid;
        logic [6:0]  keySpecificBits;
        logic [15:0] keySpecificBytes;
        logic [31:0] vendorInfo;
        logic [47:0] cmdSpecific;
    } ssdf_report_s;

    typedef enum logic [0:0] {
        SSDF_IDLE = 1'b0,
        SSDF_SEND = 1'b1
    } ssdf_state_e;

    typedef struct packed {
        ssdf_state_e   state;
        ssdf_report_s  rpt;
        logic [31:0]   info;
        logic          valid;
        logic          lmf;
        logic [6:0]    code;
        logic [7:0]    count;
        logic [7:0]    total;
        logic [7:0]    outByte;
        logic          outValid;
        logic          outLast;
    } ssdf_regs_s;

endpackage

// [rtl/ssdf_formatter.sv]
// Sense data formatter: latches one error report and streams the sense block byte by byte.
// Assumes the report comes from logic on clk_sys and the byte sink never stalls.
`timescale 1ns/1ps
`default_nettype none
module ssdf_formatter #(
    parameter logic [7:0] FIXED_LEN = ssdf_pkg::SSDF_FIXED_LEN,
    parameter logic [7:0] DESC_LEN  = ssdf_pkg::SSDF_DESC_LEN
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  reportValid,
    input  wire ssdf_pkg::ssdf_report_s report,
    output logic                       reportReady,
    output logic [7:0]                 senseByte,
    output logic                       senseValid,
    output logic                       senseLast,
    output logic [7:0]                 senseLength,
    output logic                       busy
);
    import ssdf_pkg::*;

    ssdf_regs_s state_r;
    ssdf_regs_s state_nxt;

    // Descriptor layout is produced elsewhere; this block emits zero bytes after the response code byte.
    function automatic logic [7:0] fixed_byte(input ssdf_regs_s s, input logic [4:0] idx);
        logic [7:0] b;
        b = SSDF_ZERO_BYTE;
        if (idx == SSDF_B_CODE) begin
            b = {s.valid, s.code};
        end else if (idx == SSDF_B_FLAGS) begin
            b = SSDF_ZERO_BYTE;
            b[SSDF_LMF_BIT] = s.lmf;
            b[3:0] = s.rpt.senseKey;
        end else if (idx >= SSDF_B_INFO0 && idx <= SSDF_B_INFO3) begin
            b = s.info[8 * (SSDF_B_INFO3 - idx) +: 8];
        end else if (idx == SSDF_B_ALEN) begin
            b = SSDF_ADD_LEN;
        end else if (idx == SSDF_B_ASC) begin
            b = s.rpt.addCode;
        end else if (idx == SSDF_B_ASCQ) begin
            b = s.rpt.addQual;
        end else if (idx == SSDF_B_KSF) begin
            b = {s.rpt.keySpecificValid, s.rpt.keySpecificBits};
        end else if (idx == SSDF_B_KSB0) begin
            b = s.rpt.keySpecificBytes[15:8];
        end else if (idx == SSDF_B_KSB1) begin
            b = s.rpt.keySpecificBytes[7:0];
        end else if (idx >= SSDF_B_VEN0 && idx <= SSDF_B_VEN3) begin
            b = s.rpt.vendorInfo[8 * (SSDF_B_VEN3 - idx) +: 8];
        end else if (idx >= SSDF_B_CSI0 && idx <= SSDF_B_CSI5) begin
            b = s.rpt.cmdSpecific[8 * (SSDF_B_CSI5 - idx) +: 8];
        end
        // Bytes 1, 8..11, 14, 18..19 and 30..31 fall through as zero.
        return b;
    endfunction

    function automatic logic is_long_cmd(input logic [7:0] op);
        return (op == SSDF_OP_LONG_READ) || (op == SSDF_OP_LONG_WRITE);
    endfunction

    always_comb begin
        logic [7:0] fmtLen;
        logic       fits;
        logic       v;
        logic       m;
        fmtLen = FIXED_LEN;
        fits = 1'b0;
        v = 1'b0;
        m = 1'b0;
        state_nxt = state_r;
        state_nxt.outValid = 1'b0;
        state_nxt.outLast = 1'b0;
        state_nxt.outByte = SSDF_ZERO_BYTE;
        unique case (state_r.state)
            SSDF_IDLE: begin
                if (reportValid) begin
                    fmtLen = report.descFormat ? DESC_LEN : FIXED_LEN;
                    // Residues wider than 32 bits cannot be shown in the fixed format.
                    fits = (report.infoValue[63:32] == SSDF_INFO_ZERO);
                    v = report.infoValid && (fits || report.descFormat);
                    m = report.lengthMismatch && is_long_cmd(report.opcode);
                    state_nxt.rpt = report;
                    state_nxt.valid = v && !report.descFormat;
                    state_nxt.lmf = m && v;
                    state_nxt.info = v ? report.infoValue[31:0] : SSDF_INFO_ZERO;
                    if (report.descFormat) begin
                        state_nxt.code = report.deferred ? SSDF_RC_DEF_DESC
                                                         : SSDF_RC_CUR_DESC;
                    end else begin
                        state_nxt.code = report.deferred ? SSDF_RC_DEF_FIXED
                                                         : SSDF_RC_CUR_FIXED;
                    end
                    if (report.requestSense && report.allocLen < fmtLen) begin
                        state_nxt.total = report.allocLen;
                    end else begin
                        state_nxt.total = fmtLen;
                    end
                    state_nxt.count = SSDF_ZERO_BYTE;
                    state_nxt.state = (state_nxt.total == SSDF_ZERO_BYTE) ? SSDF_IDLE
                                                                            : SSDF_SEND;
                end
            end
            SSDF_SEND: begin
                state_nxt.outByte = state_r.rpt.descFormat && state_r.count != SSDF_ZERO_BYTE
                                    ? SSDF_ZERO_BYTE
                                    : fixed_byte(state_r, state_r.count[4:0]);
                if (state_r.rpt.descFormat && state_r.count == SSDF_ZERO_BYTE) begin
                    state_nxt.outByte = {1'b0, state_r.code};
                end
                state_nxt.outValid = 1'b1;
                state_nxt.count = state_r.count + 8'h01;
                if (state_nxt.count == state_r.total) begin
                    state_nxt.outLast = 1'b1;
                    state_nxt.state = SSDF_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reportReady = (state_r.state == SSDF_IDLE);
    assign senseByte   = state_r.outByte;
    assign senseValid  = state_r.outValid;
    assign senseLast   = state_r.outLast;
    assign senseLength = state_r.total;
    assign busy        = (state_r.state == SSDF_SEND);

endmodule
`default_nettype wire

// [tb/ssdf_props.sv]
// Checker for the sense formatter: stream timing and fixed byte values.
// Assumes it is bound to ssdf_formatter and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ssdf_props import ssdf_pkg::*; #(
    parameter logic [7:0] FIXED_LEN = SSDF_FIXED_LEN,
    parameter logic [7:0] DESC_LEN  = SSDF_DESC_LEN
) (
    input wire logic         clk_sys,
    input wire logic         resetn,
    input wire logic         reportValid,
    input wire ssdf_report_s report,
    input wire logic         reportReady,
    input wire logic [7:0]   senseByte,
    input wire logic         senseValid,
    input wire logic         senseLast,
    input wire logic [7:0]   senseLength,
    input wire logic         busy
);
    logic [7:0] idx_r;
    logic       dsc_r;
    function automatic logic [7:0] expLen(ssdf_report_s r);
        logic [7:0] f;
        f = r.descFormat ? DESC_LEN : FIXED_LEN;
        return (r.requestSense && r.allocLen < f) ? r.allocLen : f;
    endfunction
    // Byte index restarts on every take, so it stays right for back-to-back blocks.
    always_ff @(posedge clk_sys) begin
        if (!resetn || (reportValid && reportReady)) idx_r <= 8'h00;
        else if (senseValid) idx_r <= idx_r + 8'h01;
        if (reportValid && reportReady) dsc_r <= report.descFormat;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_take; reportValid && reportReady; endsequence
    sequence s_lead; s_take ##2 senseValid; endsequence
    property p_code; s_lead |-> senseByte[6:0] ==
        {5'b11100, $past(report.descFormat, 2), $past(report.deferred, 2)}; endproperty
    property p_len; s_take |=> senseLength == expLen($past(report)); endproperty
    property p_start; s_take and expLen(report) != 8'h00 |=> busy ##1 senseValid; endproperty
    property p_refuse; busy |-> !reportReady; endproperty
    property p_stream; senseValid && !senseLast |=> senseValid; endproperty
    property p_last; senseLast |-> senseValid && idx_r == senseLength - 8'h01; endproperty
    property p_alen; senseValid && idx_r == 8'h07 && !dsc_r |-> senseByte == SSDF_ADD_LEN;
    endproperty
    property p_zero; senseValid && (idx_r == 8'h01 || (idx_r >= 8'h08 && idx_r <= 8'h0B))
        |-> senseByte == SSDF_ZERO_BYTE; endproperty
    property p_flags; senseValid && idx_r == 8'h02 |-> senseByte[7:6] == 2'b00 &&
        senseByte[4] == 1'b0; endproperty
    a_code: assert property (p_code) else $error("bad response code");
    a_len: assert property (p_len) else $error("bad block length");
    a_start: assert property (p_start) else $error("late first byte");
    a_refuse: assert property (p_refuse) else $error("ready while busy");
    a_stream: assert property (p_stream) else $error("gap in stream");
    a_last: assert property (p_last) else $error("last byte misplaced");
    a_alen: assert property (p_alen) else $error("bad sense length byte");
    a_zero: assert property (p_zero) else $error("nonzero reserved byte");
    a_flags: assert property (p_flags) else $error("bad flag byte");
endmodule
bind ssdf_formatter ssdf_props #(.FIXED_LEN(FIXED_LEN), .DESC_LEN(DESC_LEN)) uProps (
    .clk_sys(clk_sys), .resetn(resetn), .reportValid(reportValid), .report(report),
    .reportReady(reportReady), .senseByte(senseByte), .senseValid(senseValid),
    .senseLast(senseLast), .senseLength(senseLength), .busy(busy));
`default_nettype wire

// [tb/ssdf_sink.sv]
// Initiator-side sink: stores every sense byte the formatter hands over.
// Assumes one byte per senseValid pulse on clk_sys; it never stalls.
`timescale 1ns/1ps
`default_nettype none
module ssdf_sink (
    input  wire logic       clk_sys,
    input  wire logic       clr,
    input  wire logic [7:0] senseByte,
    input  wire logic       senseValid,
    output logic [7:0]      got [0:63],
    output int              nGot
);
    always @(posedge clk_sys) begin
        if (clr) nGot <= 0;
        else if (senseValid) begin
            got[nGot[5:0]] <= senseByte;
            nGot <= nGot + 1;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_ssdf_formatter.sv]
// Testbench for ssdf_formatter: sends error reports and checks each sense block.
// Assumes the checker is bound by its own file and the sink never stalls.
`timescale 1ns/1ps
`default_nettype none
module tb_ssdf_formatter;
    import ssdf_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, reportValid = 1'b0, clr = 1'b1;
    ssdf_report_s report = '0;
    logic reportReady, senseValid, senseLast, busy;
    logic [7:0] senseByte, senseLength, got [0:63], ex [0:59];
    int nGot, errorCnt = 0, nCompared = 0;
    logic [3:0] keys [0:10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB, 4'hE};
    always #12.5 clk_sys = ~clk_sys;
    ssdf_formatter DUT (.clk_sys(clk_sys), .resetn(resetn), .reportValid(reportValid),
        .report(report), .reportReady(reportReady), .senseByte(senseByte),
        .senseValid(senseValid), .senseLast(senseLast), .senseLength(senseLength), .busy(busy));
    ssdf_sink uSink (.clk_sys(clk_sys), .clr(clr), .senseByte(senseByte),
        .senseValid(senseValid), .got(got), .nGot(nGot));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // A nonzero hold keeps offering a junk report while busy; it must be ignored.
    task automatic run(input string name, input ssdf_report_s r, input int hold);
        logic [7:0] len;
        logic v, m;
        len = r.descFormat ? SSDF_DESC_LEN : SSDF_FIXED_LEN;
        if (r.requestSense && r.allocLen < len) len = r.allocLen;
        v = !r.descFormat && r.infoValid && r.infoValue[63:32] == 32'h0;
        m = v && r.lengthMismatch && (r.opcode inside {SSDF_OP_LONG_READ, SSDF_OP_LONG_WRITE});
        foreach (ex[i]) ex[i] = 8'h00;
        ex[0] = {v, 5'b11100, r.descFormat, r.deferred};
        if (!r.descFormat) begin
            ex[2] = {2'b00, m, 1'b0, r.senseKey};
            {ex[3], ex[4], ex[5], ex[6]} = v ? r.infoValue[31:0] : SSDF_INFO_ZERO;
            ex[7] = SSDF_ADD_LEN;
            {ex[12], ex[13]} = {r.addCode, r.addQual};
            {ex[15], ex[16], ex[17]} = {r.keySpecificValid, r.keySpecificBits, r.keySpecificBytes};
            {ex[20], ex[21], ex[22], ex[23]} = r.vendorInfo;
            {ex[24], ex[25], ex[26], ex[27], ex[28], ex[29]} = r.cmdSpecific;
        end
        @(posedge clk_sys);
        report <= r;
        reportValid <= 1'b1;
        clr <= 1'b1;
        @(posedge clk_sys);
        report <= (hold > 0) ? '1 : r;
        clr <= 1'b0;
        repeat (hold) @(posedge clk_sys);
        reportValid <= 1'b0;
        // The sink count still shows the previous block until the clear has landed.
        @(posedge clk_sys);
        for (int i = 0; i < 80 && nGot != len; i++) @(posedge clk_sys);
        chk(nGot, len);
        chk(senseLength, len);
        for (int i = 0; i < len; i++) chk(got[i], ex[i]);
        $display("test %s done", name);
    endtask
    initial begin
        ssdf_report_s r;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        r = '0;
        {r.addCode, r.addQual, r.keySpecificValid, r.keySpecificBits} = 24'h1122B3;
        {r.keySpecificBytes, r.vendorInfo} = 48'h4455_6677_8899;
        r.cmdSpecific = 48'hAABB_CCDD_EEF1;
        r.infoValid = 1'b1;
        r.infoValue = 64'h1234_5678;
        foreach (keys[k]) begin
            r.senseKey = keys[k];
            r.deferred = k[0];
            run("sense key", r, 0);
        end
        {r.opcode, r.lengthMismatch, r.infoValue} = {SSDF_OP_LONG_READ, 1'b1, 64'hFFFF_FFFC};
        run("long read residue", r, 5);
        r.opcode = SSDF_OP_LONG_WRITE;
        run("long write residue", r, 0);
        r.opcode = 8'h28;
        run("mismatch ignored", r, 0);
        r.infoValue = 64'h1_0000_0000;
        run("wide information", r, 0);
        {r.infoValid, r.infoValue} = {1'b0, 64'h5};
        run("invalid information", r, 0);
        r.descFormat = 1'b1;
        run("descriptor", r, 0);
        {r.deferred, r.requestSense, r.allocLen} = {1'b0, 1'b1, 8'h40};
        run("request descriptor", r, 0);
        {r.descFormat, r.allocLen} = {1'b0, 8'h12};
        run("request short", r, 0);
        r.allocLen = 8'h00;
        run("request empty", r, 0);
        wrap_up();
    end
    initial begin
        repeat (10000) @(posedge clk_sys);
        errorCnt++;
        wrap_up();
    end
endmodule
`default_nettype wire
